// *** hdl/pwct_timer.sv ***
// Free-running prescaled 16-bit counter with one edge-selectable input capture.
`timescale 1ns/100ps
`default_nettype none
module pwct_timer
  import pwct_pkg::*;
#(
  parameter int unsigned PRESCALE = PWCT_PRESCALE,
  parameter int unsigned CNT_W    = PWCT_CNT_W
)
(
  // Clock and reset.
  input  wire logic       sys_clk,
  input  wire logic       resetn,

  // Pulse source.
  input  wire logic       capture_input_pin,

  // Software controls.
  input  wire pwct_ctrl_s ctrl,

  // State for software and the counter advance strobe.
  output var pwct_stat_s  stat,
  output var logic        timer_tick
);

  // Timing as seen from outside the block.
  // The counter steps on each edge that ends a cycle with timer_tick high.
  // The first edge that samples a new pin level of the selected polarity also loads the capture register and flag.
  // The captured count is the one that stood just before that edge.
  // Clear inputs are single-cycle pulses; a set in the same cycle wins over them.
  // The pin is sampled directly, so the pulse source must be synchronous to sys_clk.
  // Software must flip the edge selection between the two edges of a pulse.
  // Otherwise the second edge is lost, so short pulses need a separate pin reader.
  // The pin level itself is not reported, as the capture path only sees edges.
  // Rollovers beyond one wrap are left for software to tally from the overflow flag.
  // A rollover that lands on a captured edge sets both flags in the same cycle.
  // Deciding which side of the edge that rollover belongs to is left to software.

  // Elaboration checks.
  // The status carrier and the three-bit prescaler fix both figures, so other values are refused.
  if (PRESCALE != PWCT_PRESCALE) begin : g_check_prescale
    $error("PRESCALE must equal the fixed divide-by-eight prescaler.");
  end

  if (CNT_W != PWCT_CNT_W) begin : g_check_width
    $error("CNT_W must match the sixteen-bit counter carried in the status.");
  end

  localparam logic [2:0]  PRE_STEP = 3'h1;
  localparam logic [15:0] CNT_STEP = 16'h0001;

  // Edge test shared by both capture polarities.
  function automatic logic edge_match(
    input logic       now_lvl,
    input logic       prev_lvl,
    input pwct_edge_e dir
  );
    case (dir)
      PWCT_EDGE_RISING: begin
        edge_match = now_lvl && !prev_lvl;
      end
      PWCT_EDGE_FALLING: begin
        edge_match = !now_lvl && prev_lvl;
      end
      default: begin
        edge_match = 1'b0;
      end
    endcase
  endfunction : edge_match

  // Sticky flag update; a set landing on a clear wins so no event is lost.
  function automatic logic sticky_next(
    input logic cur_in,
    input logic set_in,
    input logic clr_in
  );
    if (set_in) begin
      sticky_next = 1'b1;
    end else if (clr_in) begin
      sticky_next = 1'b0;
    end else begin
      sticky_next = cur_in;
    end
  endfunction : sticky_next

  // Prescaler and counter.
  logic [2:0]  pre_reg;
  logic [15:0] cnt_reg;

  // Capture path.
  logic [15:0] cap_reg;
  logic        pin_reg;
  logic        pin_seen_reg;

  // Flags.
  logic        cap_flag_reg;
  logic        ovf_flag_reg;

  // Next values.
  logic [2:0]  pre_next;
  logic [15:0] cnt_next;
  logic [15:0] cap_next;
  logic        pin_next;
  logic        pin_seen_next;
  logic        cap_flag_next;
  logic        ovf_flag_next;

  // Decode.
  wire         tick_w;
  wire         wrap_w;
  wire         rise_w;
  wire         fall_w;
  wire         capture_w;
  pwct_edge_e  edge_sel_w;

  // The tick marks the last prescaler state before the counter steps.
  assign tick_w     = (pre_reg == PWCT_PRE_LAST);
  assign wrap_w     = tick_w && (cnt_reg == PWCT_CNT_MAX);

  // The first sample after reset only primes the detector, so no false edge follows reset.
  assign rise_w     = pin_seen_reg && edge_match(capture_input_pin, pin_reg, PWCT_EDGE_RISING);
  assign fall_w     = pin_seen_reg && edge_match(capture_input_pin, pin_reg, PWCT_EDGE_FALLING);

  // Only the armed edge captures; the other edge is dropped until the selection flips.
  assign edge_sel_w = pwct_edge_e'(ctrl.capture_edge_select);
  assign capture_w  = (edge_sel_w == PWCT_EDGE_RISING) ? rise_w : fall_w;

  // Counting.
  assign pre_next      = pre_reg + PRE_STEP;
  assign cnt_next      = tick_w ? (cnt_reg + CNT_STEP) : cnt_reg;

  // Capturing.
  assign cap_next      = capture_w ? cnt_reg : cap_reg;
  assign pin_next      = capture_input_pin;
  assign pin_seen_next = 1'b1;

  // Flags.
  assign cap_flag_next = sticky_next(cap_flag_reg, capture_w, ctrl.clear_capture_flag);
  assign ovf_flag_next = sticky_next(ovf_flag_reg, wrap_w, ctrl.clear_overflow_flag);

  // Prescaler.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pre_reg <= PWCT_PRE_RESET;
    end else begin
      pre_reg <= pre_next;
    end
  end

  // Counter.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= PWCT_CNT_RESET;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // Capture register.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cap_reg <= PWCT_CAP_RESET;
    end else begin
      cap_reg <= cap_next;
    end
  end

  // Previous pin sample.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pin_reg <= 1'b0;
    end else begin
      pin_reg <= pin_next;
    end
  end

  // Edge detector primed.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pin_seen_reg <= 1'b0;
    end else begin
      pin_seen_reg <= pin_seen_next;
    end
  end

  // Capture flag.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cap_flag_reg <= 1'b0;
    end else begin
      cap_flag_reg <= cap_flag_next;
    end
  end

  // Overflow flag.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ovf_flag_reg <= 1'b0;
    end else begin
      ovf_flag_reg <= ovf_flag_next;
    end
  end

  // Outputs come straight from registers, except the tick strobe.
  assign stat.counter_value      = cnt_reg;
  assign stat.capture_value      = cap_reg;
  assign stat.capture_event_flag = cap_flag_reg;
  assign stat.overflow_flag      = ovf_flag_reg;
  assign timer_tick              = tick_w;

endmodule : pwct_timer
`default_nettype wire

// *** hdl/pwct_pkg.sv ***
// Package of constants and carrier types for the pulse width capture timer.
// Overview of operation
// - Counter advances once every eight oscillator cycles.
// - Capture either polarity, full rollover, one-tick resolution.
// - Capture only on currently selected edge.
// - Capture pin level not readable; use separate input.
// - Rising capture raises first event; software selects falling.
// - Captured edge holds counter value for software.
// - Each rollover raises an overflow event.
package pwct_pkg;

  localparam int unsigned PWCT_PRESCALE     = 8;
  localparam int unsigned PWCT_CNT_W        = 16;
  localparam logic [15:0] PWCT_CNT_RESET    = 16'h0000;
  localparam logic [15:0] PWCT_CAP_RESET    = 16'h0000;
  localparam logic [15:0] PWCT_CNT_MAX      = 16'hFFFF;
  localparam logic [2:0]  PWCT_PRE_RESET    = 3'h0;
  localparam logic [2:0]  PWCT_PRE_LAST     = 3'h7;

  typedef enum logic {
    PWCT_EDGE_FALLING,
    PWCT_EDGE_RISING
  } pwct_edge_e;

  // Software side controls: flag clears are one-cycle pulses.
  typedef struct packed {
    logic capture_edge_select;
    logic clear_capture_flag;
    logic clear_overflow_flag;
  } pwct_ctrl_s;

  typedef struct packed {
    logic [15:0] counter_value;
    logic [15:0] capture_value;
    logic        capture_event_flag;
    logic        overflow_flag;
  } pwct_stat_s;

endpackage : pwct_pkg

// *** bench/pwct_props.sv ***
// Port checker of the capture timer.
`timescale 1ns/100ps
`default_nettype none
module pwct_props import pwct_pkg::*; (input wire logic sys_clk, resetn, capture_input_pin,
  input wire pwct_ctrl_s ctrl, input wire pwct_stat_s stat, input wire logic timer_tick);
  wire [15:0] c = stat.counter_value;
  wire s = ctrl.capture_edge_select;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  property p_st; timer_tick |=> c == $past(c) + 16'h1; endproperty
  a_st: assert property (p_st) else $error("step");
  property p_sp; timer_tick |=> !timer_tick [*7] ##1 timer_tick; endproperty
  a_sp: assert property (p_sp) else $error("tick gap");
  property p_wr; timer_tick && c == 16'hFFFF |=> stat.overflow_flag && c == 16'h0000; endproperty
  a_wr: assert property (p_wr) else $error("wrap");
  property p_ov; $rose(stat.overflow_flag) |-> $past(c) == 16'hFFFF; endproperty
  a_ov: assert property (p_ov) else $error("overflow");
  property p_cp; (s ? $rose(capture_input_pin) : $fell(capture_input_pin))
    |=> stat.capture_event_flag && stat.capture_value == $past(c); endproperty
  a_cp: assert property (p_cp) else $error("capture");
  property p_ig; (s ? $fell(capture_input_pin) : $rose(capture_input_pin)) |=> $stable(stat.capture_value); endproperty
  a_ig: assert property (p_ig) else $error("ignored edge");
  cover property (stat.capture_event_flag && !s);
  cover property (ctrl.clear_capture_flag);
  cover property (timer_tick);
endmodule : pwct_props
bind pwct_timer pwct_props i_props (.sys_clk, .resetn, .capture_input_pin, .ctrl, .stat, .timer_tick);
`default_nettype wire

// *** bench/pwct_src.sv ***
// Pulse source model.
`timescale 1ns/100ps
`default_nettype none
module pwct_src (input wire logic sys_clk, output var logic pin);
  initial pin = 1'b0;
  // Edges only on clock edges, since the pin has no synchroniser.
  task automatic pulse(input int w);
    @(posedge sys_clk) pin <= 1'b1;
    repeat (w) @(posedge sys_clk);
    pin <= 1'b0;
  endtask : pulse
endmodule : pwct_src
`default_nettype wire

// *** bench/test_pulse_width_capture_timer.sv ***
// Bench of the capture timer.
`timescale 1ns/100ps
`default_nettype none
module test_pulse_width_capture_timer;
  import pwct_pkg::*;
  logic sys_clk = 0, resetn = 0, pin, tick;
  pwct_ctrl_s ctrl = '0;
  pwct_stat_s stat;
  int n_fail = 0, n_compared = 0, cyc = 0;
  logic [15:0] s;
  always #50 sys_clk = ~sys_clk;
  pwct_timer i_dut (.sys_clk, .resetn, .capture_input_pin(pin), .ctrl, .stat, .timer_tick(tick));
  pwct_src i_src (.sys_clk, .pin);
  task automatic chk(input logic [15:0] g, e);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic wflag(input int n);
    repeat (n) if (stat.capture_event_flag !== 1'b1) @(negedge sys_clk);
  endtask : wflag
  task automatic t_width(input int w);
    ctrl <= 3'h4;
    fork
      i_src.pulse(w);
      begin
        wflag(20);
        chk(stat.capture_event_flag, 16'h1);
        s = stat.capture_value;
        @(posedge sys_clk) ctrl <= 3'h2;
        @(posedge sys_clk) ctrl <= 3'h0;
        @(negedge sys_clk) chk(stat.capture_event_flag, 16'h0);
        wflag(w + 20);
        chk(stat.capture_value - s, 16'(w / 8));
        chk(stat.overflow_flag, 16'h0);
      end
    join
    $display("width test done");
  endtask : t_width
  task automatic t_tick;
    logic [15:0] c0;
    @(negedge sys_clk);
    while (tick !== 1'b1) @(negedge sys_clk);
    c0 = stat.counter_value;
    repeat (8) @(negedge sys_clk);
    chk(tick, 16'h1);
    chk(stat.counter_value, c0 + 16'h1);
    $display("tick test done");
  endtask : t_tick
  task automatic t_miss;
    @(posedge sys_clk) ctrl <= 3'h6;
    @(posedge sys_clk) ctrl <= 3'h4;
    @(negedge sys_clk);
    fork
      i_src.pulse(24);
      begin
        wflag(20);
        s = stat.capture_value;
      end
    join
    repeat (4) @(negedge sys_clk);
    chk(stat.capture_value, s);
    $display("missed edge test done");
  endtask : t_miss
  task automatic stop_test;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  always @(posedge sys_clk) if (++cyc == 5000) begin
    n_fail++;
    stop_test;
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    t_tick;
    @(posedge sys_clk);
    t_width(160);
    t_miss;
    stop_test;
  end
endmodule : test_pulse_width_capture_timer
`default_nettype wire
